/* dv/port_io_crossbar_gpio_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module port_io_crossbar_gpio_assertions (
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_sfr_addr,
    input wire logic        i_sfr_wr,
    input wire logic [7:0]  i_sfr_wdata,
    input wire logic        i_sfr_rd,
    input wire logic        i_sfr_rmw,
    input wire logic [7:0]  o_sfr_rdata,
    input wire logic        i_twowire_route_en,
    input wire logic        i_match_irq_enable,
    input wire logic [15:0] i_pin_in,
    input wire logic [15:0] o_pin_out,
    input wire logic [15:0] o_pin_oe,
    input wire logic [15:0] o_pin_pullup,
    input wire logic        o_port0_match,
    input wire logic        o_match_irq,
    input wire logic        o_osc_wake
);
    // ----------------------------------------
    // register shadow and quiet counters
    // ----------------------------------------
    logic [7:0]  sh [0:255];
    logic [15:0] pin_q;
    logic [2:0]  quiet;
    logic [2:0]  mz;
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 256; i++) sh[i] <= 8'h00;
            sh[8'h80] <= 8'hFF;
            sh[8'hD7] <= 8'hFF;
            sh[8'hF1] <= 8'hFF;
            pin_q <= 16'h0000;
            quiet <= 3'h0;
            mz <= 3'h0;
        end else begin
            if (i_sfr_wr) sh[i_sfr_addr] <= i_sfr_wdata;
            pin_q <= i_pin_in;
            // any write or pin edge restarts the settling window
            if (i_sfr_wr || i_pin_in != pin_q) quiet <= 3'h0;
            else if (quiet != 3'h7) quiet <= quiet + 3'h1;
            if (sh[8'hC7] != 8'h00) mz <= 3'h0;
            else if (mz != 3'h7) mz <= mz + 3'h1;
        end
    end
    wire [7:0] ain = sh[8'hF1];
    wire [7:0] lat = sh[8'h80];
    wire [7:0] ra = sh[8'hE1];
    wire [7:0] rb = sh[8'hE2];
    wire       mexp = |(((i_pin_in[7:0] & ain) ^ sh[8'hD7]) & sh[8'hC7]);
    wire       nop = ra[5:0] == 6'h00 && rb[5:3] == 3'h0 && rb[1:0] == 2'h0
                     && !i_twowire_route_en;
    wire [7:0] goe = rb[6] ? (ain & (~lat | sh[8'hA4])) : 8'h00;
    wire       mapped = i_sfr_addr inside {8'h80, 8'h90, 8'hA4, 8'hC7,
                        8'hD4, 8'hD7, 8'hE1, 8'hE2, 8'hF1};

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_rmw_rd;
        i_sfr_rd && i_sfr_rmw && i_sfr_addr == 8'h80;
    endsequence
    sequence s_xb_off;
        !rb[6] [*3];
    endsequence

    a_unmapped_read: assert property (i_sfr_rd && !mapped |=>
        o_sfr_rdata == 8'h00) else $error("unmapped read not zero");
    a_route_a_top: assert property (
        i_sfr_rd && i_sfr_addr == 8'hE1 |=> o_sfr_rdata[7:6] == 2'b00)
        else $error("route a top bits not zero");
    a_rmw_latch: assert property (s_rmw_rd |=>
        o_sfr_rdata == $past(lat)) else $error("rmw read not latch");
    a_xbar_off_quiet: assert property (s_xb_off |->
        o_pin_oe == 16'h0000) else $error("driver on while disabled");
    a_gpio_drive: assert property (quiet >= 6 && nop |->
        o_pin_oe[7:0] == goe && ((o_pin_out[7:0] ^ lat) & goe) == 8'h00)
        else $error("gpio drive wrong");
    a_pullup_rule: assert property (quiet >= 6 |->
        (o_pin_pullup[7:0] & ~ain) == 8'h00 &&
        (!rb[7] || o_pin_pullup == 16'h0000)) else $error("pullup wrong");
    a_match_value: assert property (quiet >= 6 |->
        o_port0_match == mexp) else $error("match level wrong");
    a_mask_zero: assert property (mz >= 6 |->
        !o_port0_match) else $error("match with empty mask");
    a_wake_match: assert property (
        o_osc_wake == o_port0_match) else $error("wake differs from match");
    a_irq_gate: assert property (
        (i_match_irq_enable == $past(i_match_irq_enable) && quiet >= 6)[*2]
        |-> o_match_irq == (o_port0_match && i_match_irq_enable))
        else $error("irq gate wrong");
endmodule
`default_nettype wire

/* dv/port_io_crossbar_gpio_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module port_io_crossbar_gpio_tb;
    logic        clk, rst_n, wr, rd, rmw, four, tw, irq_en, tx;
    logic        rx, match, irq, wake;
    logic [7:0]  addr, wdata, rdata, q, d;
    logic [14:0] p_out, p_oe, p_in;
    logic [15:0] ext, pin, pout, poe, pup;
    logic [7:0]  m [0:255];
    int          n_errors, n_tests;
    localparam logic [7:0] ADDRS [10] = '{8'h80, 8'h90, 8'hA4, 8'hC7,
        8'hD4, 8'hD7, 8'hE1, 8'hE2, 8'hF1, 8'h00};
    // ----------------------------------------
    // clock, pins, design and host
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    assign pin = (poe & pout) | (~poe & ext);
    port_io_crossbar_gpio #(.UART_LOW_PINS(0)) port_io_crossbar_gpio_i (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr),
        .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_sfr_rd(rd), .i_sfr_rmw(rmw),
        .o_sfr_rdata(rdata), .i_spi_four_wire(four),
        .i_twowire_route_en(tw), .i_match_irq_enable(irq_en),
        .i_periph_out(p_out), .i_periph_oe(p_oe), .o_periph_in(p_in),
        .i_serial_transmit(tx), .o_serial_receive(rx), .i_pin_in(pin),
        .o_pin_out(pout), .o_pin_oe(poe), .o_pin_pullup(pup),
        .o_port0_match(match), .o_match_irq(irq), .o_osc_wake(wake));
    sfr_host_model sfr_host_model_i (.i_core_clk(clk), .i_sfr_rdata(rdata),
        .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd), .o_rmw(rmw));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] v);
        sfr_host_model_i.wr(a, v);
        m[a] = (a == 8'hE2) ? (v & 8'hFB) : v;
    endtask
    function automatic logic [7:0] exp_rd(input logic [7:0] a,
                                          input logic r);
        case (a)
            8'h80: return r ? m[a] : pin[7:0] & m[8'hF1];
            8'h90: return r ? m[a] : pin[15:8];
            8'hE1: return m[a] & 8'h3F;
            8'hA4, 8'hC7, 8'hD4, 8'hD7, 8'hE2, 8'hF1: return m[a];
            default: return 8'h00;
        endcase
    endfunction
    task automatic read_all();
        for (int i = 0; i < 10; i++) begin
            for (int r = 0; r < 2; r++) begin
                sfr_host_model_i.rd(ADDRS[i], r[0], q);
                chk(q, exp_rd(ADDRS[i], r[0]), "read");
            end
        end
    endtask
    task automatic check_pins();
        logic [15:0] taken, used, gp, eoe, dig, eff, lat, u, pp;
        logic [14:0] en, ein;
        logic [7:0]  ra, rb;
        logic        xb, mt, eo;
        logic [1:0]  ep;
        ra = m[8'hE1];
        rb = m[8'hE2];
        xb = rb[6];
        dig = {8'hFF, m[8'hF1]};
        pp = {8'h00, m[8'hA4]};
        eff = pin & dig;
        lat = {m[8'h90], m[8'h80]};
        u = (xb && ra[0]) ? 16'h0030 : 16'h0000;
        en = {rb[5:3], rb[1:0] == 2'b11, rb[1], rb[1:0] != 2'b00, ra[3],
              ra[5], ra[4], tw, tw, ra[1] & four, {3{ra[1]}}};
        taken = {8'h00, m[8'hD4]} | u;
        used = 16'h0000;
        ein = '1;
        for (int s = 0; s < 15; s++) begin
            for (int p = 0; p < 16; p++) begin
                if (xb && en[s] && !taken[p]) begin
                    taken[p] = 1'b1;
                    used[p] = 1'b1;
                    ein[s] = eff[p];
                    if (s == 4 || s == 5) chk(poe[p] & pout[p], 0, "od");
                    eo = p_oe[s] && dig[p] && (!p_out[s] ||
                         (pp[p] && s != 4 && s != 5));
                    ep = {eo, eo & p_out[s]};
                    chk({poe[p], poe[p] & pout[p]}, ep, "pdrv");
                    break;
                end
            end
        end
        gp = ~used & ~u;
        eoe = xb ? dig & (~lat | {8'h00, m[8'hA4]}) : 16'h0000;
        chk(poe & gp, eoe & gp, "oe");
        chk(pout & eoe & gp, lat & eoe & gp, "out");
        chk(pup & gp, ~{16{rb[7]}} & dig & ~eoe & gp, "pullup");
        chk(p_in, ein, "periph");
        chk(rx, u[5] ? eff[5] : 1'b1, "rx");
        eo = dig[4] && (!tx || pp[4]);
        ep = {eo, eo & tx};
        if (u[4]) chk({poe[4], poe[4] & pout[4]}, ep, "tx");
        if (u[5]) chk(poe[5], 0, "rx oe");
        mt = |((eff[7:0] ^ m[8'hD7]) & m[8'hC7]);
        chk({match, irq, wake}, {mt, mt & irq_en, mt}, "match");
    endtask
    task automatic conclude();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        {four, tw, irq_en, tx} = 4'h1;
        p_out = 15'h0000;
        p_oe = 15'h0000;
        ext = 16'hA55A;
        n_errors = 0;
        n_tests = 0;
        void'($urandom(32'hE59A4A07));
        for (int i = 0; i < 256; i++) m[i] = 8'h00;
        m[8'h80] = 8'hFF;
        m[8'h90] = 8'hFF;
        m[8'hD7] = 8'hFF;
        m[8'hF1] = 8'hFF;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        check_pins();
        read_all();
        put(8'hE1, 8'hFF);
        for (int k = 0; k < 60; k++) begin
            for (int i = 0; i < 10; i++) begin
                d = $urandom();
                if (ADDRS[i] == 8'hE1) d = (k % 3 == 0) ? 8'h00 : d & 8'h3F;
                if (ADDRS[i] == 8'hE2)
                    d = {d[7], k % 5 != 0, (k % 3) ? d[5:0] : 6'h00};
                if (ADDRS[i] == 8'hC7 && k % 4 == 0) d = 8'h00;
                put(ADDRS[i], d);
            end
            {four, tw, irq_en, tx} = $urandom();
            if (k % 3 == 0) tw = 1'b0;
            p_out = $urandom();
            p_oe = $urandom();
            ext = $urandom();
            repeat (8) @(posedge clk);
            #1;
            check_pins();
            read_all();
        end
        conclude();
    end
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule
bind port_io_crossbar_gpio port_io_crossbar_gpio_assertions
    port_io_crossbar_gpio_assertions_i (.*);
`default_nettype wire

/* dv/sfr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_sfr_rdata,
    output var logic  [7:0] o_addr,
    output var logic        o_wr,
    output var logic  [7:0] o_wdata,
    output var logic        o_rd,
    output var logic        o_rmw
);
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_wdata = 8'h00;
        o_rd = 1'b0;
        o_rmw = 1'b0;
    end
    // released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        #1;
        o_addr = a;
        o_wdata = (a == 8'hE2) ? (d & 8'hFB) : d;
        o_wr = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~o_wdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic r,
                      output logic [7:0] q);
        @(posedge i_core_clk);
        #1;
        o_addr = a;
        o_rmw = r;
        o_rd = 1'b1;
        @(posedge i_core_clk);
        #1;
        q = i_sfr_rdata;
        o_rd = 1'b0;
        o_rmw = ~r;
        o_addr = ~a;
    endtask
endmodule
`default_nettype wire

/* logic/port_io_crossbar_gpio.v */
`timescale 1ns/1ps
`default_nettype none
`include "port_io_crossbar_gpio_consts.vh"

module port_io_crossbar_gpio #(
    parameter UART_LOW_PINS = 0
) (
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    input  wire [7:0]  i_sfr_addr,
    input  wire        i_sfr_wr,
    input  wire [7:0]  i_sfr_wdata,
    input  wire        i_sfr_rd,
    input  wire        i_sfr_rmw,
    output reg  [7:0]  o_sfr_rdata,
    input  wire        i_spi_four_wire,
    input  wire        i_twowire_route_en,
    input  wire        i_match_irq_enable,
    input  wire [14:0] i_periph_out,
    input  wire [14:0] i_periph_oe,
    output reg  [14:0] o_periph_in,
    input  wire        i_serial_transmit,
    output reg         o_serial_receive,
    input  wire [15:0] i_pin_in,
    output reg  [15:0] o_pin_out,
    output reg  [15:0] o_pin_oe,
    output reg  [15:0] o_pin_pullup,
    output reg         o_port0_match,
    output reg         o_match_irq,
    output reg         o_osc_wake
);

// ----------------------------------------
// reset release
// ----------------------------------------
reg rst_meta_n;
reg rst_sync_n;

always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        rst_meta_n <= 1'b0;
        rst_sync_n <= 1'b0;
    end else begin
        rst_meta_n <= 1'b1;
        rst_sync_n <= rst_meta_n;
    end
end

// ----------------------------------------
// helpers
// ----------------------------------------
function [3:0] lowest;
    input [14:0] v;
    integer k;
    begin
        lowest = `NONE_IDX;
        for (k = `NSIG - 1; k >= 0; k = k - 1) begin
            if (v[k]) begin
                lowest = k[3:0];
            end
        end
    end
endfunction

function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
        hit = (addr == target);
    end
endfunction

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] port0_data;
reg [7:0] port1_data;
reg [7:0] port0_output_drive;
reg [7:0] port0_compare_mask;
reg [7:0] port0_crossbar_bypass;
reg [7:0] port0_compare_value;
reg [7:0] pin_route_select_a;
reg [7:0] pin_route_select_b;
reg [7:0] port0_analog_select;

always @(posedge i_core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        port0_data            <= `RST_PORT_DATA;
        port1_data            <= `RST_PORT_DATA;
        port0_output_drive    <= `RST_PORT0_DRIVE;
        port0_compare_mask    <= `RST_PORT0_MASK;
        port0_crossbar_bypass <= `RST_PORT0_BYPASS; // R21
        port0_compare_value   <= `RST_PORT0_VALUE;
        pin_route_select_a    <= `RST_ROUTE;
        pin_route_select_b    <= `RST_ROUTE;
        port0_analog_select   <= `RST_PORT0_ANALOG; // R18
    end else if (i_sfr_wr) begin
        if (hit(i_sfr_addr, `ADDR_PORT0_DATA)) begin
            port0_data <= i_sfr_wdata; // R11
        end
        if (hit(i_sfr_addr, `ADDR_PORT1_DATA)) begin
            port1_data <= i_sfr_wdata; // R11
        end
        if (hit(i_sfr_addr, `ADDR_PORT0_DRIVE)) begin
            port0_output_drive <= i_sfr_wdata;
        end
        if (hit(i_sfr_addr, `ADDR_PORT0_MASK)) begin
            port0_compare_mask <= i_sfr_wdata;
        end
        if (hit(i_sfr_addr, `ADDR_PORT0_BYPASS)) begin
            port0_crossbar_bypass <= i_sfr_wdata;
        end
        if (hit(i_sfr_addr, `ADDR_PORT0_VALUE)) begin
            port0_compare_value <= i_sfr_wdata;
        end
        if (hit(i_sfr_addr, `ADDR_ROUTE_A)) begin
            pin_route_select_a <= i_sfr_wdata & `WMASK_ROUTE_A; // R1
        end
        if (hit(i_sfr_addr, `ADDR_ROUTE_B)) begin
            // reserved bit is dropped so a stray one cannot steer anything
            pin_route_select_b <= i_sfr_wdata & `WMASK_ROUTE_B; // R9
        end
        if (hit(i_sfr_addr, `ADDR_PORT0_ANALOG)) begin
            port0_analog_select <= i_sfr_wdata;
        end
    end
end

// ----------------------------------------
// pin synchronizer
// ----------------------------------------
reg [15:0] pin_meta;
reg [15:0] pin_sync;

always @(posedge i_core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        pin_meta <= 16'hFFFF;
        pin_sync <= 16'hFFFF;
    end else begin
        pin_meta <= i_pin_in; // R25
        pin_sync <= pin_meta;
    end
end

// ----------------------------------------
// decoded controls
// ----------------------------------------
wire        router_enable;
wire        pullup_disable;
wire        async_serial_route_en;
wire [1:0]  compare_module_route_sel;
wire [15:0] digital;
wire [15:0] push_pull;
wire [3:0]  tx_pin;
wire [3:0]  rx_pin;

assign router_enable = pin_route_select_b[`RB_ROUTER_EN]; // R7
assign pullup_disable = pin_route_select_b[`RB_PULLUP_DIS];
assign async_serial_route_en = pin_route_select_a[`RA_UART];
assign compare_module_route_sel = pin_route_select_b[1:0];
// port 1 has no mode registers here: digital and open-drain
assign digital = {8'hFF, port0_analog_select}; // R18
assign push_pull = {8'h00, port0_output_drive};
assign tx_pin = (UART_LOW_PINS != 0) ? 4'h3 : 4'h4; // R5
assign rx_pin = tx_pin + 4'h1;

// ----------------------------------------
// signal requests
// ----------------------------------------
reg [14:0] want;

always @* begin
    want = 15'h0000;
    want[`SIG_SCK]  = pin_route_select_a[`RA_SPI]; // R4
    want[`SIG_MISO] = pin_route_select_a[`RA_SPI];
    want[`SIG_MOSI] = pin_route_select_a[`RA_SPI];
    want[`SIG_NSS]  = pin_route_select_a[`RA_SPI] & i_spi_four_wire; // R4
    want[`SIG_SDA]  = i_twowire_route_en;
    want[`SIG_SCL]  = i_twowire_route_en;
    want[`SIG_CMP_SYNC]  = pin_route_select_a[`RA_CMP_SYNC]; // R2
    want[`SIG_CMP_ASYNC] = pin_route_select_a[`RA_CMP_ASYNC]; // R2
    want[`SIG_CLK_N] = pin_route_select_a[`RA_CLK_OUT]; // R3
    want[`SIG_COMPARE_MODULE_OUT_A] = (compare_module_route_sel != 2'b00); // R10
    want[`SIG_CEX1] = compare_module_route_sel[1]; // R10
    want[`SIG_CEX2] = (compare_module_route_sel == 2'b11); // R10
    want[`SIG_ECI] = pin_route_select_b[`RB_ECI]; // R8
    want[`SIG_T0]  = pin_route_select_b[`RB_T0]; // R8
    want[`SIG_T1]  = pin_route_select_b[`RB_T1]; // R8
end

// ----------------------------------------
// priority assignment and pin drive
// ----------------------------------------
reg [14:0] remain;
reg [15:0] taken;
reg [15:0] assigned;
reg [63:0] assign_idx;
reg [3:0]  pick;
reg        val;
reg        drive;
reg        od_forced;
reg [15:0] next_pin_out;
reg [15:0] next_pin_oe;
reg [15:0] next_pin_pullup;
integer    p;

always @* begin
    remain = want;
    taken = {8'h00, port0_crossbar_bypass}; // R21
    assigned = 16'h0000;
    assign_idx = {16{`NONE_IDX}};
    pick = `NONE_IDX;
    val = 1'b1;
    drive = 1'b0;
    od_forced = 1'b0;
    next_pin_out = 16'hFFFF;
    next_pin_oe = 16'h0000;
    next_pin_pullup = 16'h0000;
    if (async_serial_route_en) begin
        taken[tx_pin] = 1'b1; // R5
        taken[rx_pin] = 1'b1;
    end
    for (p = 0; p < `NPIN; p = p + 1) begin
        if (!taken[p] && (remain != 15'h0000)) begin
            pick = lowest(remain); // R23
            remain[pick] = 1'b0;
            assigned[p] = 1'b1;
            assign_idx[4*p +: 4] = pick;
        end
        val = (p < 8) ? port0_data[p % 8] : port1_data[p % 8];
        drive = 1'b1;
        od_forced = 1'b0;
        if (async_serial_route_en && (p == tx_pin)) begin
            val = i_serial_transmit;
        end else if (async_serial_route_en && (p == rx_pin)) begin
            drive = 1'b0;
        end else if (assigned[p]) begin
            pick = assign_idx[4*p +: 4];
            val = i_periph_out[pick];
            drive = i_periph_oe[pick];
            od_forced = (pick == `SIG_SDA) || (pick == `SIG_SCL); // R20
        end
        if (!router_enable || !digital[p]) begin
            drive = 1'b0; // R24
        end
        if (drive && !val) begin
            next_pin_out[p] = 1'b0; // R16
            next_pin_oe[p] = 1'b1;
        end else if (drive && push_pull[p] && !od_forced) begin
            next_pin_out[p] = 1'b1; // R19
            next_pin_oe[p] = 1'b1;
        end
        // pullup only helps a released open-drain high
        next_pin_pullup[p] = !pullup_disable && digital[p] // R6
                             && !next_pin_oe[p];
    end
    if (!router_enable) begin
        assigned = 16'h0000; // R7
    end
end

// ----------------------------------------
// peripheral inputs
// ----------------------------------------
reg [14:0] next_periph_in;
reg        next_serial_receive;
integer    q;

always @* begin
    next_periph_in = 15'h7FFF;
    next_serial_receive = 1'b1;
    for (q = 0; q < `NPIN; q = q + 1) begin
        if (assigned[q]) begin
            next_periph_in[assign_idx[4*q +: 4]] = pin_sync[q] & digital[q];
        end
    end
    if (router_enable && async_serial_route_en) begin
        next_serial_receive = pin_sync[rx_pin] & digital[rx_pin]; // R18
    end
end

// ----------------------------------------
// match detection
// ----------------------------------------
wire [7:0] port0_level;
wire       next_match;

// analog pins have their receiver off and read low
assign port0_level = pin_sync[7:0] & port0_analog_select; // R17
assign next_match = ((port0_level & port0_compare_mask) // R14
                    != (port0_compare_value & port0_compare_mask)); // R22

// ----------------------------------------
// register read
// ----------------------------------------
reg [7:0] next_rdata;

always @* begin
    next_rdata = 8'h00;
    case (i_sfr_addr)
        `ADDR_PORT0_DATA: begin
            if (i_sfr_rmw) begin
                next_rdata = port0_data; // R13
            end else begin
                next_rdata = port0_level; // R12
            end
        end
        `ADDR_PORT1_DATA: begin
            if (i_sfr_rmw) begin
                next_rdata = port1_data; // R13
            end else begin
                next_rdata = pin_sync[15:8]; // R12
            end
        end
        `ADDR_PORT0_DRIVE: begin
            next_rdata = port0_output_drive;
        end
        `ADDR_PORT0_MASK: begin
            next_rdata = port0_compare_mask;
        end
        `ADDR_PORT0_BYPASS: begin
            next_rdata = port0_crossbar_bypass;
        end
        `ADDR_PORT0_VALUE: begin
            next_rdata = port0_compare_value;
        end
        `ADDR_ROUTE_A: begin
            next_rdata = pin_route_select_a & `WMASK_ROUTE_A; // R1
        end
        `ADDR_ROUTE_B: begin
            next_rdata = pin_route_select_b;
        end
        `ADDR_PORT0_ANALOG: begin
            next_rdata = port0_analog_select;
        end
        default: begin
            next_rdata = 8'h00;
        end
    endcase
end

// ----------------------------------------
// output flops
// ----------------------------------------
// every output is registered, so pins trail their causes by one clock;
// the comparator async path loses its asynchrony here as a result
always @(posedge i_core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
        o_sfr_rdata      <= 8'h00;
        o_periph_in      <= 15'h7FFF;
        o_serial_receive <= 1'b1;
        o_pin_out        <= 16'hFFFF;
        o_pin_oe         <= 16'h0000;
        o_pin_pullup     <= 16'h0000;
        o_port0_match    <= 1'b0;
        o_match_irq      <= 1'b0;
        o_osc_wake       <= 1'b0;
    end else begin
        if (i_sfr_rd) begin
            o_sfr_rdata <= next_rdata;
        end
        o_periph_in      <= next_periph_in;
        o_serial_receive <= next_serial_receive;
        o_pin_out        <= next_pin_out;
        o_pin_oe         <= next_pin_oe;
        o_pin_pullup     <= next_pin_pullup;
        o_port0_match    <= next_match; // R25
        o_match_irq      <= next_match & i_match_irq_enable; // R15
        o_osc_wake       <= next_match; // R15
    end
end

endmodule
`default_nettype wire

/* logic/port_io_crossbar_gpio_consts.vh */
// What this block does
// R1: first routing register bits 7:6 always read zero; software writes zeros there.
// R2: first routing bits 5 and 4 route comparator async and sync outputs to pins.
// R3: first routing bit 3 routes the inverted system clock to a pin.
// R4: serial peripheral enable routes its signals on three or four pins.
// R5: first routing bit 0 routes serial transmit/receive to fixed port 0 pins.
// R6: second routing bit 7 low enables weak pullups except on analog pins; the block also turns them off on pins whose driver is on.
// R7: second routing bit 6 enables the crossbar; cleared, no peripheral routing.
// R8: second routing bits 5,4,3 route timer one, timer zero, counter clock inputs.
// R9: software writes zero to reserved bit 2 of second routing register.
// R10: two-bit module field routes none, module 0, modules 0-1, or 0-2.
// R11: port data writes store an output latch driving unassigned pins.
// R12: normal port data reads return actual pin levels, even for peripheral pins.
// R13: read-modify-write reads of a port return the latch, not the pins.
// R14: match event when masked pin levels differ from masked compare value.
// R15: match event requests interrupt when enabled, and wakes the oscillator.
// R16: latch 0 drives low; latch 1 drives high if push-pull, else floats.
// R17: port reads return 0 for analog pins, pin level for digital pins.
// R18: input-mode bit 0 makes pin analog with pullup, driver, receiver off.
// R19: output-mode bit 0 open-drain, 1 push-pull; ignored for analog pins.
// R20: two-wire bus data and clock pins are always open-drain.
// R21: skip bit 1 makes the crossbar pass over that pin; resets to zero.
// R22: mask bit 0 excludes a pin from the match; 1 compares it.
// R23: peripherals take lowest free, unskipped pins in priority order.
// R24: crossbar disabled keeps all pins as inputs with drivers off.
// R25: pins are synchronized before matching; match stays a level while mismatched.
`ifndef PORT_IO_CROSSBAR_GPIO_CONSTS_VH
`define PORT_IO_CROSSBAR_GPIO_CONSTS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_PORT0_DATA      8'h80
`define ADDR_PORT1_DATA      8'h90
`define ADDR_PORT0_DRIVE     8'hA4
`define ADDR_PORT0_MASK      8'hC7
`define ADDR_PORT0_BYPASS    8'hD4
`define ADDR_PORT0_VALUE     8'hD7
`define ADDR_ROUTE_A         8'hE1
`define ADDR_ROUTE_B         8'hE2
`define ADDR_PORT0_ANALOG    8'hF1

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define RST_PORT_DATA        8'hFF
`define RST_PORT0_DRIVE      8'h00
`define RST_PORT0_MASK       8'h00
`define RST_PORT0_BYPASS     8'h00
`define RST_PORT0_VALUE      8'hFF
`define RST_ROUTE            8'h00
`define RST_PORT0_ANALOG     8'hFF
`define WMASK_ROUTE_A        8'h3F
`define WMASK_ROUTE_B        8'hFB

// ----------------------------------------
// field positions
// ----------------------------------------
`define RA_CMP_ASYNC         5
`define RA_CMP_SYNC          4
`define RA_CLK_OUT           3
`define RA_SPI               1
`define RA_UART              0
`define RB_PULLUP_DIS        7
`define RB_ROUTER_EN         6
`define RB_T1                5
`define RB_T0                4
`define RB_ECI               3

// ----------------------------------------
// crossbar signal order, highest priority first
// ----------------------------------------
`define SIG_SCK              0
`define SIG_MISO             1
`define SIG_MOSI             2
`define SIG_NSS              3
`define SIG_SDA              4
`define SIG_SCL              5
`define SIG_CMP_SYNC         6
`define SIG_CMP_ASYNC        7
`define SIG_CLK_N            8
`define SIG_COMPARE_MODULE_OUT_A             9
`define SIG_CEX1             10
`define SIG_CEX2             11
`define SIG_ECI              12
`define SIG_T0               13
`define SIG_T1               14
`define NSIG                 15
`define NPIN                 16
`define NONE_IDX             4'hF

`endif
